// ---- design/dbg_tap_cfg.svh ----
// constants for the debug and test access block
`ifndef DBG_TAP_CFG_SVH
`define DBG_TAP_CFG_SVH
`define OFF_CTRL         8'h00
`define OFF_STATUS       8'h04
`define OFF_COMMS_TX     8'h08
`define OFF_COMMS_RX     8'h0C
`define WP_PAGE0         3'h1
`define WP_PAGE1         3'h2
`define WP_ADDR_F        3'h0
`define WP_AMASK_F       3'h1
`define WP_DATA_F        3'h2
`define WP_DMASK_F       3'h3
`define WP_CTRL_F        3'h4
`define CTRL_HALT_BIT    1
`define CTRL_RESTART_BIT 2
`define WPC_EN_BIT       0
`define WPC_EXT_BIT      1
`define WPC_EXT_SEL_BIT  2
`define ST_DEBUG_BIT     0
`define ST_RX_FULL_BIT   1
`define ST_TX_EMPTY_BIT  2
`define ST_RANGE_LSB     3
`define ST_CAUSE_LSB     5
`define IR_EXTEST        4'h0
`define IR_SCAN_N        4'h2
`define IR_RESTART       4'h4
`define IR_INTEST        4'hC
`define IR_IDCODE        4'hE
`define IR_BYPASS        4'hF
`define IR_CAPTURE       4'h1
`define CHAIN_RESET      5'h00
`define CHAIN_COMMS      5'h01
`define CHAIN_EXT        5'h03
`define DR_MSB_WORD      5'h1F
`define DR_MSB_SCAN_N    5'h04
`define DR_MSB_BYPASS    5'h00
`endif

// ---- design/dbg_tap_pkg.sv ----
// types shared by the debug and test access block
package dbg_tap_pkg;
  typedef enum logic [3:0] {
    TAP_RESET   = 4'hF,
    TAP_IDLE    = 4'hC,
    TAP_SEL_DR  = 4'h7,
    TAP_CAP_DR  = 4'h6,
    TAP_SH_DR   = 4'h2,
    TAP_EX1_DR  = 4'h1,
    TAP_PA_DR   = 4'h3,
    TAP_EX2_DR  = 4'h0,
    TAP_UPD_DR  = 4'h5,
    TAP_SEL_IR  = 4'h4,
    TAP_CAP_IR  = 4'hE,
    TAP_SH_IR   = 4'hA,
    TAP_EX1_IR  = 4'h9,
    TAP_PA_IR   = 4'hB,
    TAP_EX2_IR  = 4'h8,
    TAP_UPD_IR  = 4'hD
  } tap_state_t;
endpackage

// ---- design/pin_sync.sv ----
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- design/tap_fsm.sv ----
// test access port state machine
`timescale 1ns/100ps
`default_nettype none
module tap_fsm (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        adv,
  input  wire logic        tms,
  output dbg_tap_pkg::tap_state_t state_q
);
  dbg_tap_pkg::tap_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      dbg_tap_pkg::TAP_RESET:  state_d = tms ? dbg_tap_pkg::TAP_RESET  : dbg_tap_pkg::TAP_IDLE;
      dbg_tap_pkg::TAP_IDLE:   state_d = tms ? dbg_tap_pkg::TAP_SEL_DR : dbg_tap_pkg::TAP_IDLE;
      dbg_tap_pkg::TAP_SEL_DR: state_d = tms ? dbg_tap_pkg::TAP_SEL_IR : dbg_tap_pkg::TAP_CAP_DR;
      dbg_tap_pkg::TAP_CAP_DR: state_d = tms ? dbg_tap_pkg::TAP_EX1_DR : dbg_tap_pkg::TAP_SH_DR;
      dbg_tap_pkg::TAP_SH_DR:  state_d = tms ? dbg_tap_pkg::TAP_EX1_DR : dbg_tap_pkg::TAP_SH_DR;
      dbg_tap_pkg::TAP_EX1_DR: state_d = tms ? dbg_tap_pkg::TAP_UPD_DR : dbg_tap_pkg::TAP_PA_DR;
      dbg_tap_pkg::TAP_PA_DR:  state_d = tms ? dbg_tap_pkg::TAP_EX2_DR : dbg_tap_pkg::TAP_PA_DR;
      dbg_tap_pkg::TAP_EX2_DR: state_d = tms ? dbg_tap_pkg::TAP_UPD_DR : dbg_tap_pkg::TAP_SH_DR;
      dbg_tap_pkg::TAP_UPD_DR: state_d = tms ? dbg_tap_pkg::TAP_SEL_DR : dbg_tap_pkg::TAP_IDLE;
      dbg_tap_pkg::TAP_SEL_IR: state_d = tms ? dbg_tap_pkg::TAP_RESET  : dbg_tap_pkg::TAP_CAP_IR;
      dbg_tap_pkg::TAP_CAP_IR: state_d = tms ? dbg_tap_pkg::TAP_EX1_IR : dbg_tap_pkg::TAP_SH_IR;
      dbg_tap_pkg::TAP_SH_IR:  state_d = tms ? dbg_tap_pkg::TAP_EX1_IR : dbg_tap_pkg::TAP_SH_IR;
      dbg_tap_pkg::TAP_EX1_IR: state_d = tms ? dbg_tap_pkg::TAP_UPD_IR : dbg_tap_pkg::TAP_PA_IR;
      dbg_tap_pkg::TAP_PA_IR:  state_d = tms ? dbg_tap_pkg::TAP_EX2_IR : dbg_tap_pkg::TAP_PA_IR;
      dbg_tap_pkg::TAP_EX2_IR: state_d = tms ? dbg_tap_pkg::TAP_UPD_IR : dbg_tap_pkg::TAP_SH_IR;
      dbg_tap_pkg::TAP_UPD_IR: state_d = tms ? dbg_tap_pkg::TAP_SEL_DR : dbg_tap_pkg::TAP_IDLE;
      default:                 state_d = dbg_tap_pkg::TAP_RESET;
    endcase
  end

  // moves only on enabled test clock edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dbg_tap_pkg::TAP_RESET;
    end else if (adv) begin
      state_q <= state_d;
    end
  end
endmodule
`default_nettype wire

// ---- design/debug_tap_signal_interface.sv ----
// debug state, watchpoints, comms channel and test access port of the core
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dbg_tap_cfg.svh"
module debug_tap_signal_interface #(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001  // arbitrary identification value
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fetch_done,
  input  wire logic        pipe_advance,
  input  wire logic        pipe_flush,
  input  wire logic        exec_valid,
  input  wire logic        exec_cond_pass,
  input  wire logic        data_req_done,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_data,
  input  wire logic        data_watch_halt_in,
  input  wire logic        instr_break_halt_in,
  input  wire logic [1:0]  external_condition_in,
  input  wire logic        debug_features_enable,
  input  wire logic        external_halt_request,
  input  wire logic        test_reset_n,
  input  wire logic        test_clock_enable,
  input  wire logic        test_mode_select,
  input  wire logic        test_serial_in,
  input  wire logic        ext_chain_shift_in,
  output logic             comms_rx_full,
  output logic             comms_tx_empty,
  output logic             debug_state_ack,
  output logic             instr_executed_out,
  output logic      [1:0]  watch_range_match,
  output logic             internal_halt_request,
  output logic      [3:0]  tap_instr_value,
  output logic      [4:0]  selected_chain_id,
  output logic      [3:0]  tap_state_code,
  output logic             test_serial_out,
  output logic             test_out_enable_n,
  output logic             ext_chain_shift_out
);
  logic        dbg_en_s;
  logic        ext_req_s;
  logic        tck_s;
  logic        tms_s;
  logic        tdi_s;
  logic        chain_in_s;
  logic        dbg_rst_n;
  logic        adv;
  dbg_tap_pkg::tap_state_t tap_st;

  // debug internal state also cleared by the test reset pin, level sensitive
  assign dbg_rst_n = presetn & test_reset_n;

  pin_sync #(.W(6)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (clk_en),
    .d     ({debug_features_enable, external_halt_request, test_clock_enable,
             test_mode_select, test_serial_in, ext_chain_shift_in}),
    .q     ({dbg_en_s, ext_req_s, tck_s, tms_s, tdi_s, chain_in_s})
  );

  assign adv = clk_en & tck_s;

  tap_fsm u_tap (
    .clk     (pclk),
    .rst_n   (dbg_rst_n),
    .adv     (adv),
    .tms     (tms_s),
    .state_q (tap_st)
  );

  // ---------------- apb slave ----------------
  logic        acc;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] rdata_d;
  logic        map_err;
  logic [31:0] ctrl_q;
  logic [31:0] tx_data_q;
  logic [31:0] rx_data_q;
  logic [31:0] wp_addr_q  [2];
  logic [31:0] wp_amask_q [2];
  logic [31:0] wp_data_q  [2];
  logic [31:0] wp_dmask_q [2];
  logic [2:0]  wp_ctrl_q  [2];
  logic [2:0]  cause_q;
  logic        dbg_q;

  function automatic logic wp_page(input logic [7:0] a, output logic idx);
    idx = (a[7:5] == `WP_PAGE1);
    return ((a[7:5] == `WP_PAGE0) || (a[7:5] == `WP_PAGE1)) && (a[4:2] <= `WP_CTRL_F)
           && (a[1:0] == 2'h0);
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    logic i;
    addr_ok = (a == `OFF_CTRL) || (a == `OFF_STATUS) || (a == `OFF_COMMS_TX)
              || (a == `OFF_COMMS_RX) || wp_page(a, i);
  endfunction

  // answer one cycle into the access phase
  assign acc     = clk_en & psel & penable;
  assign wr_fire = acc & pready & pwrite & addr_ok(paddr);
  assign rd_fire = acc & pready & !pwrite & addr_ok(paddr);

  always_comb begin
    logic wi;
    wi = 1'b0;
    rdata_d = 32'h0000_0000;
    map_err = 1'b0;
    if (paddr == `OFF_CTRL) begin
      rdata_d = ctrl_q;
    end else if (paddr == `OFF_STATUS) begin
      rdata_d[`ST_DEBUG_BIT]    = dbg_q;
      rdata_d[`ST_RX_FULL_BIT]  = comms_rx_full;
      rdata_d[`ST_TX_EMPTY_BIT] = comms_tx_empty;
      rdata_d[`ST_RANGE_LSB +: 2] = watch_range_match;
      rdata_d[`ST_CAUSE_LSB +: 3] = cause_q;
    end else if (paddr == `OFF_COMMS_TX) begin
      rdata_d = tx_data_q;
    end else if (paddr == `OFF_COMMS_RX) begin
      rdata_d = rx_data_q;
    end else if (wp_page(paddr, wi)) begin
      if (paddr[4:2] == `WP_ADDR_F) begin
        rdata_d = wp_addr_q[wi];
      end else if (paddr[4:2] == `WP_AMASK_F) begin
        rdata_d = wp_amask_q[wi];
      end else if (paddr[4:2] == `WP_DATA_F) begin
        rdata_d = wp_data_q[wi];
      end else if (paddr[4:2] == `WP_DMASK_F) begin
        rdata_d = wp_dmask_q[wi];
      end else begin
        rdata_d[2:0] = wp_ctrl_q[wi];
      end
    end else begin
      map_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel & penable & !pready;
      pslverr <= psel & penable & !pready & map_err;
      prdata  <= (psel & penable & !pready & !pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

  // restart bit is a one-shot request, it never stays set
  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      ctrl_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (wr_fire && paddr == `OFF_CTRL) begin
        ctrl_q <= pwdata;
      end else begin
        ctrl_q[`CTRL_RESTART_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      for (int i = 0; i < 2; i++) begin
        wp_addr_q[i]  <= 32'h0000_0000;
        wp_amask_q[i] <= 32'hFFFF_FFFF;
        wp_data_q[i]  <= 32'h0000_0000;
        wp_dmask_q[i] <= 32'hFFFF_FFFF;
        wp_ctrl_q[i]  <= 3'h0;
      end
    end else if (clk_en && wr_fire && paddr[7:5] != 3'h0) begin
      if (paddr[4:2] == `WP_ADDR_F) begin
        wp_addr_q[paddr[6]] <= pwdata;
      end else if (paddr[4:2] == `WP_AMASK_F) begin
        wp_amask_q[paddr[6]] <= pwdata;
      end else if (paddr[4:2] == `WP_DATA_F) begin
        wp_data_q[paddr[6]] <= pwdata;
      end else if (paddr[4:2] == `WP_DMASK_F) begin
        wp_dmask_q[paddr[6]] <= pwdata;
      end else begin
        wp_ctrl_q[paddr[6]] <= pwdata[2:0];
      end
    end
  end

  // ---------------- watchpoints ----------------
  function automatic logic masked_eq(input logic [31:0] v, input logic [31:0] r,
                                     input logic [31:0] m);
    return ((v ^ r) & ~m) == 32'h0000_0000;
  endfunction

  logic [1:0] range_d;
  logic [1:0] wp_hit;

  // mask bits set mean "don't care"
  for (genvar g = 0; g < 2; g++) begin : g_wp
    logic ext_ok;
    assign ext_ok = !wp_ctrl_q[g][`WPC_EXT_BIT]
                    | external_condition_in[wp_ctrl_q[g][`WPC_EXT_SEL_BIT]];
    assign range_d[g] = masked_eq(bus_addr, wp_addr_q[g], wp_amask_q[g])
                        & masked_eq(bus_data, wp_data_q[g], wp_dmask_q[g]) & ext_ok;
    assign wp_hit[g]  = range_d[g] & wp_ctrl_q[g][`WPC_EN_BIT] & data_req_done;
  end

  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      watch_range_match <= 2'h0;
    end else if (clk_en) begin
      watch_range_match <= range_d;
    end
  end

  // ---------------- debug state ----------------
  logic bp_dec_q;
  logic bp_exe_q;
  logic halt_watch;
  logic halt_break;
  logic halt_req;
  logic enter;
  logic restart_tap;
  logic leave;
  logic [3:0] ir_sh_q;

  // a breakpoint tag rides with its instruction; flushed or spent tags never halt
  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      bp_dec_q <= 1'b0;
      bp_exe_q <= 1'b0;
    end else if (clk_en) begin
      if (pipe_flush || halt_break) begin
        bp_dec_q <= 1'b0;
        bp_exe_q <= 1'b0;
      end else begin
        if (pipe_advance) begin
          bp_exe_q <= bp_dec_q;
          bp_dec_q <= 1'b0;
        end
        if (fetch_done) begin
          bp_dec_q <= instr_break_halt_in;
        end
      end
    end
  end

  assign halt_watch  = data_req_done & (data_watch_halt_in | (|wp_hit));
  assign halt_break  = exec_valid & bp_exe_q;
  assign halt_req    = ext_req_s | ctrl_q[`CTRL_HALT_BIT];
  assign enter       = dbg_en_s & !dbg_q & (halt_watch | halt_break | halt_req);
  // decode the word being loaded, the old instruction is still on the output
  assign restart_tap = adv && tap_st == dbg_tap_pkg::TAP_UPD_IR
                       && ir_sh_q == `IR_RESTART;
  assign leave       = restart_tap || ctrl_q[`CTRL_RESTART_BIT];

  // entry wins over a restart arriving in the same cycle
  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      dbg_q   <= 1'b0;
      cause_q <= 3'h0;
    end else if (clk_en) begin
      if (enter) begin
        dbg_q   <= 1'b1;
        cause_q <= {halt_req, halt_break, halt_watch};
      end else if (leave) begin
        dbg_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      debug_state_ack       <= 1'b0;
      internal_halt_request <= 1'b0;
      instr_executed_out    <= 1'b0;
    end else if (clk_en) begin
      debug_state_ack       <= enter | (dbg_q & !leave);
      internal_halt_request <= halt_req;
      instr_executed_out    <= exec_valid & exec_cond_pass & !dbg_q & !enter;
    end
  end

  // ---------------- tap registers ----------------
  logic [31:0] dr_sh_q;
  logic        comms_sel;
  logic        ext_sel;
  logic        sh_ir;
  logic        sh_dr;
  logic [4:0]  dr_msb;

  function automatic logic [4:0] msb_of(input logic [3:0] ir, input logic [4:0] ch);
    if (ir == `IR_IDCODE) begin
      return `DR_MSB_WORD;
    end else if (ir == `IR_SCAN_N) begin
      return `DR_MSB_SCAN_N;
    end else if ((ir == `IR_INTEST || ir == `IR_EXTEST) && ch == `CHAIN_COMMS) begin
      return `DR_MSB_WORD;
    end else begin
      return `DR_MSB_BYPASS;
    end
  endfunction

  assign sh_ir     = tap_st == dbg_tap_pkg::TAP_SH_IR;
  assign sh_dr     = tap_st == dbg_tap_pkg::TAP_SH_DR;
  assign comms_sel = (tap_instr_value == `IR_INTEST || tap_instr_value == `IR_EXTEST)
                     && selected_chain_id == `CHAIN_COMMS;
  assign ext_sel   = (tap_instr_value == `IR_INTEST || tap_instr_value == `IR_EXTEST)
                     && selected_chain_id == `CHAIN_EXT;
  assign dr_msb    = msb_of(tap_instr_value, selected_chain_id);

  // every tap register except tap_state_code holds unless the test clock enable is high
  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      ir_sh_q         <= `IR_IDCODE;
      tap_instr_value <= `IR_IDCODE;
    end else if (adv) begin
      if (tap_st == dbg_tap_pkg::TAP_RESET) begin
        tap_instr_value <= `IR_IDCODE;
      end else if (tap_st == dbg_tap_pkg::TAP_CAP_IR) begin
        ir_sh_q <= `IR_CAPTURE;
      end else if (sh_ir) begin
        ir_sh_q <= {tdi_s, ir_sh_q[3:1]};
      end else if (tap_st == dbg_tap_pkg::TAP_UPD_IR) begin
        tap_instr_value <= ir_sh_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      dr_sh_q           <= 32'h0000_0000;
      selected_chain_id <= `CHAIN_RESET;
    end else if (adv) begin
      if (tap_st == dbg_tap_pkg::TAP_CAP_DR) begin
        if (tap_instr_value == `IR_IDCODE) begin
          dr_sh_q <= ID_VALUE;
        end else if (tap_instr_value == `IR_SCAN_N) begin
          dr_sh_q <= {27'h0000000, selected_chain_id};
        end else if (comms_sel) begin
          dr_sh_q <= tx_data_q;
        end else begin
          dr_sh_q <= 32'h0000_0000;
        end
      end else if (sh_dr) begin
        dr_sh_q         <= dr_sh_q >> 1;
        dr_sh_q[dr_msb] <= tdi_s;
      end else if (tap_st == dbg_tap_pkg::TAP_UPD_DR
                   && tap_instr_value == `IR_SCAN_N) begin
        selected_chain_id <= dr_sh_q[4:0];
      end
    end
  end

  // serial out lags the shift edge by one enabled edge
  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      test_serial_out     <= 1'b0;
      test_out_enable_n   <= 1'b1;
      ext_chain_shift_out <= 1'b0;
    end else if (adv) begin
      test_serial_out     <= sh_ir ? ir_sh_q[0] : (ext_sel ? chain_in_s : dr_sh_q[0]);
      test_out_enable_n   <= !(sh_ir | sh_dr);
      ext_chain_shift_out <= (sh_dr & ext_sel) ? tdi_s : ext_chain_shift_out;
    end
  end

  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      tap_state_code <= dbg_tap_pkg::TAP_RESET;
    end else if (clk_en) begin
      tap_state_code <= tap_st;
    end
  end

  // ---------------- comms channel ----------------
  logic cap_tx;
  logic upd_rx;

  assign cap_tx = adv && tap_st == dbg_tap_pkg::TAP_CAP_DR && comms_sel;
  assign upd_rx = adv && tap_st == dbg_tap_pkg::TAP_UPD_DR && comms_sel;

  // a debugger fill in the same cycle as a software read keeps the flag set
  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      rx_data_q     <= 32'h0000_0000;
      comms_rx_full <= 1'b0;
    end else if (clk_en) begin
      if (upd_rx) begin
        rx_data_q     <= dr_sh_q;
        comms_rx_full <= 1'b1;
      end else if (rd_fire && paddr == `OFF_COMMS_RX) begin
        comms_rx_full <= 1'b0;
      end
    end
  end

  // writes while the transmit buffer is full are dropped
  always_ff @(posedge pclk or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      tx_data_q      <= 32'h0000_0000;
      comms_tx_empty <= 1'b1;
    end else if (clk_en) begin
      if (wr_fire && paddr == `OFF_COMMS_TX && comms_tx_empty) begin
        tx_data_q      <= pwdata;
        comms_tx_empty <= 1'b0;
      end else if (cap_tx) begin
        comms_tx_empty <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/debug_tap_signal_interface_asserts.sv ----
// port checks for the debug and test access block
`timescale 1ns/100ps
`default_nettype none
module debug_tap_signal_interface_asserts (
  input wire logic       pclk, presetn, test_reset_n, clk_en, pwrite, pready,
  input wire logic       data_req_done, data_watch_halt_in, debug_features_enable,
  input wire logic       external_halt_request, exec_valid, exec_cond_pass,
  input wire logic       test_clock_enable, debug_state_ack, internal_halt_request,
  input wire logic       instr_executed_out,
  input wire logic [3:0] tap_instr_value, tap_state_code,
  input wire logic [4:0] selected_chain_id
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !test_reset_n);
  property p_watch_entry;
    clk_en && $past(debug_features_enable, 2) && data_req_done && data_watch_halt_in
      |=> debug_state_ack;
  endproperty
  a_watch_entry: assert property (p_watch_entry) else $error("no watch entry");
  // ack may only drop after a register write or an instruction update
  property p_leave;
    $fell(debug_state_ack) |-> $past(pready && pwrite, 2)
      || $past(tap_state_code) == dbg_tap_pkg::TAP_UPD_IR;
  endproperty
  a_leave: assert property (p_leave) else $error("ack dropped");
  property p_ir_hold;
    !$stable(tap_instr_value) |-> tap_state_code == dbg_tap_pkg::TAP_UPD_IR;
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instr moved");
  property p_chain_hold;
    !$stable(selected_chain_id) |-> tap_state_code == dbg_tap_pkg::TAP_UPD_DR;
  endproperty
  a_chain_hold: assert property (p_chain_hold) else $error("chain moved");
  // pin passes two sync stages before it may step the state machine
  property p_freeze;
    !$past(test_clock_enable, 2) && !$past(test_clock_enable, 3)
      && !$past(test_clock_enable, 4) |-> $stable(tap_state_code);
  endproperty
  a_freeze: assert property (p_freeze) else $error("tap moved");
  property p_ihr;
    (external_halt_request && clk_en) [*4] |=> internal_halt_request;
  endproperty
  a_ihr: assert property (p_ihr) else $error("halt request lost");
  property p_ext_entry;
    (external_halt_request && debug_features_enable && clk_en) [*5] |=> debug_state_ack;
  endproperty
  a_ext_entry: assert property (p_ext_entry) else $error("no request entry");
  // an instruction that passes outside debug state is flagged executed unless debug state is entered
  property p_exec;
    clk_en && exec_valid && exec_cond_pass && !debug_state_ack
      |=> instr_executed_out || debug_state_ack;
  endproperty
  a_exec: assert property (p_exec) else $error("no executed flag");
  c_entry: cover property ($rose(debug_state_ack));
  c_upd_dr: cover property (tap_state_code == dbg_tap_pkg::TAP_UPD_DR);
  c_write: cover property (pready && pwrite);
endmodule
bind debug_tap_signal_interface debug_tap_signal_interface_asserts i_chk (.*);
`default_nettype wire

// ---- bench/jtag_host.sv ----
// external debugger model driving the test access pins
`timescale 1ns/100ps
`default_nettype none
module jtag_host (
  input  wire logic pclk,
  input  wire logic ext_chain_shift_out,
  input  wire logic test_serial_out,
  input  wire logic test_out_enable_n,
  output logic      test_clock_enable,
  output logic      test_mode_select,
  output logic      test_serial_in,
  output logic      ext_chain_shift_in
);
  logic [31:0] tdo_seen;
  logic        oe_n_seen;
  initial begin
    test_clock_enable = '0;
    test_mode_select = '0;
    test_serial_in = '0;
    ext_chain_shift_in = '0;
  end
  // one-bit external chain looped back
  always @(posedge pclk) ext_chain_shift_in <= ext_chain_shift_out;
  // pins invert between steps so a stale level never looks valid
  task automatic step(input logic m, input logic d);
    @(posedge pclk);
    test_clock_enable <= '1;
    test_mode_select <= m;
    test_serial_in <= d;
    @(posedge pclk);
    test_clock_enable <= '0;
    test_mode_select <= ~m;
    test_serial_in <= ~d;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] v);
    step('1, '0);
    if (ir) step('1, '0);
    step('0, '0);
    step('0, '0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i]);
      tdo_seen[i] = test_serial_out;
      oe_n_seen = test_out_enable_n;
    end
    step('1, '0);
    step('0, '0);
  endtask
endmodule
`default_nettype wire

// ---- bench/debug_tap_signal_interface_bench.sv ----
// self-checking bench for the debug and test access block
`timescale 1ns/100ps
`default_nettype none
module debug_tap_signal_interface_bench;
  logic pclk = '0, presetn = '0, test_reset_n = '0, clk_en = '1, psel = '0, penable = '0;
  logic pwrite = '0, fetch_done = '0, pipe_advance = '0, pipe_flush = '0, exec_valid = '0;
  logic exec_cond_pass = '0, data_req_done = '0, data_watch_halt_in = '0;
  logic instr_break_halt_in = '0, debug_features_enable = '1, external_halt_request = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, bus_addr = '0, bus_data = '0, prdata, r;
  logic [1:0] external_condition_in = '0, watch_range_match;
  logic pready, pslverr, comms_rx_full, comms_tx_empty, debug_state_ack, err;
  logic instr_executed_out, internal_halt_request, test_serial_out, test_out_enable_n;
  logic ext_chain_shift_out, test_clock_enable, test_mode_select, test_serial_in;
  logic ext_chain_shift_in;
  logic [3:0] tap_instr_value, tap_state_code;
  logic [4:0] selected_chain_id;
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #20 pclk = ~pclk;
  debug_tap_signal_interface i_dut (.*);
  jtag_host i_host (.*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= '1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= '1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    err = pslverr;
    psel <= '0;
    penable <= '0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= '1;
    test_reset_n <= '1;
    wt(1);
    chk("state", tap_state_code, 4'hF);
    chk("instr", tap_instr_value, 4'hE);
    chk("tx_empty", comms_tx_empty, 1'h1);
    chk("out_en_n", test_out_enable_n, 1'h1);
    apb('1, 8'h24, '0);
    apb('1, 8'h20, 32'h100);
    bus_addr <= 32'h100;
    wt(2);
    chk("range", watch_range_match, 2'h3);
    bus_addr <= 32'h104;
    wt(2);
    chk("range", watch_range_match, 2'h2);
    apb('1, 8'h50, 32'h6);
    wt(2);
    chk("range", watch_range_match, 2'h0);
    external_condition_in <= 2'h2;
    wt(2);
    chk("range", watch_range_match, 2'h2);
    apb('0, 8'h80, '0);
    chk("slverr", err, 1'h1);
    apb('1, 8'h08, 32'hA5C3_0F1E);
    wt(1);
    chk("tx_empty", comms_tx_empty, 1'h0);
    i_host.step('0, '0);
    chk("state", tap_state_code, 4'hC);
    i_host.scan('1, 4, 32'h2);
    chk("instr", tap_instr_value, 4'h2);
    i_host.scan('0, 5, 32'h1);
    chk("chain", selected_chain_id, 5'h01);
    i_host.scan('1, 4, 32'hC);
    i_host.scan('0, 32, 32'h1234_5678);
    chk("tdo", i_host.tdo_seen, 32'hA5C3_0F1E);
    chk("out_en_n", i_host.oe_n_seen, 1'h0);
    chk("rx_full", comms_rx_full, 1'h1);
    chk("tx_empty", comms_tx_empty, 1'h1);
    apb('0, 8'h0C, '0);
    chk("rx_data", r, 32'h1234_5678);
    wt(1);
    chk("rx_full", comms_rx_full, 1'h0);
    i_host.scan('1, 4, 32'h2);
    i_host.scan('0, 5, 32'h3);
    chk("chain", selected_chain_id, 5'h03);
    i_host.scan('1, 4, 32'hC);
    i_host.scan('0, 8, 32'hA5);
    chk("ext_chain", i_host.tdo_seen[7:1], 7'h25);
    data_req_done <= '1;
    data_watch_halt_in <= '1;
    wt(1);
    data_req_done <= '0;
    data_watch_halt_in <= '0;
    chk("ack", debug_state_ack, 1'h1);
    apb('1, 8'h00, 32'h4);
    wt(1);
    chk("ack", debug_state_ack, 1'h0);
    fetch_done <= '1;
    instr_break_halt_in <= '1;
    wt(1);
    fetch_done <= '0;
    instr_break_halt_in <= '0;
    pipe_advance <= '1;
    wt(1);
    pipe_advance <= '0;
    exec_valid <= '1;
    exec_cond_pass <= '1;
    wt(1);
    exec_valid <= '0;
    wt(1);
    chk("ack", debug_state_ack, 1'h1);
    i_host.scan('1, 4, 32'h4);
    chk("ack", debug_state_ack, 1'h0);
    exec_valid <= '1;
    wt(1);
    chk("executed", instr_executed_out, 1'h1);
    exec_valid <= '0;
    external_halt_request <= '1;
    wt(6);
    chk("halt_req", internal_halt_request, 1'h1);
    chk("ack", debug_state_ack, 1'h1);
    external_halt_request <= '0;
    wt(4);
    test_reset_n <= '0;
    #2;
    chk("ack", debug_state_ack, 1'h0);
    chk("state", tap_state_code, 4'hF);
    wt(2);
    test_reset_n <= '1;
    apb('1, 8'h00, 32'h2);
    wt(2);
    chk("halt_req", internal_halt_request, 1'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
